// File: dasf_pkg.sv
// Constants shared by the converter status flag logic
// Function
// - The status register answers at address d8, reads 00 after reset and accepts single-bit writes.
// - The primary ready flag in bit 7 is set when the primary converter finishes a conversion or calibration.
// - Software may clear the primary ready flag, and any mode-field write also clears it.
// - While the primary ready flag is set, no new primary result or coefficient is written.
// - The auxiliary ready flag in bit 6 behaves the same way for the auxiliary converter.
// - The calibration flag in bit 5 is set when a calibration ends and cleared by a mode-field write.
// - Software writes never clear the calibration flag.
// - The missing-reference flag in bit 4 is held low while both converters are powered down.
// - The missing-reference flag follows a floating or low reference while a converter is active.
// - With the missing-reference flag set and the external reference selected, results are all ones.
// - The primary error flag in bit 3 is set when a written primary result is all zeros or all ones.
// - A failed primary calibration sets the primary error flag and leaves the coefficients alone.
// - A mode-field write clears the primary error flag.
// - The auxiliary error flag in bit 2 does the same for the auxiliary converter.
// - A completed single conversion asks for the mode field to be written back to power-down.
// - Every mode-field write, changed or not, counts as a converter reset that clears every flag except the missing-reference flag.
package dasf_pkg;
	localparam logic [7:0] DASF_STATUS_ADDR  = 8'hd8;
	localparam logic [7:0] DASF_STATUS_RESET = 8'h00;
	localparam logic [2:0] DASF_BIT_PRDY     = 3'h7;
	localparam logic [2:0] DASF_BIT_ARDY     = 3'h6;
	localparam logic [2:0] DASF_BIT_CAL      = 3'h5;
	localparam logic [2:0] DASF_BIT_NOREF    = 3'h4;
	localparam logic [2:0] DASF_BIT_PERR     = 3'h3;
	localparam logic [2:0] DASF_BIT_AERR     = 3'h2;
	localparam int         DASF_PRIM_W       = 24;
	localparam int         DASF_AUX_W        = 16;
	localparam int         DASF_SYNC_N       = 2;
	localparam logic [2:0] DASF_MODE_OFF     = 3'h0;
	localparam logic [2:0] DASF_MODE_SINGLE  = 3'h2;
	typedef enum logic [0:0]
	{
		DASF_REF_EXT_OFF = 1'b0,
		DASF_REF_EXT_ON  = 1'b1
	} dasf_ref_sel_t;
endpackage

// File: dasf_sync.sv
// Two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
module dasf_sync
(
	input  wire logic ref_clk_i,
	input  wire logic rst_n_i,
	input  wire logic async_i,
	output logic      sync_o
);
	logic meta;

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			meta   <= 1'b0;
			sync_o <= 1'b0;
		end
		else
		begin
			meta   <= async_i;
			sync_o <= meta;
		end
	end
endmodule

// File: dasf_chan.sv
// Ready and error flags with result gating for one converter
`timescale 1ns/10ps
module dasf_chan
#(
	parameter int W = 16
)
(
	input  wire logic         ref_clk_i,
	input  wire logic         rst_n_i,
	input  wire logic         conv_done_i,
	input  wire logic         cal_done_i,
	input  wire logic         cal_fail_i,
	input  wire logic [W-1:0] raw_i,
	input  wire logic         force_ones_i,
	input  wire logic         mode_wr_i,
	input  wire logic         sw_rdy_wr_i,
	input  wire logic         sw_rdy_i,
	input  wire logic         sw_err_wr_i,
	input  wire logic         sw_err_i,
	output logic              rdy_o,
	output logic              err_o,
	output logic              result_wr_o,
	output logic [W-1:0]      result_o,
	output logic              cal_wr_o
);
	logic         take_conv;
	logic         take_cal;
	logic [W-1:0] forced;
	logic         clamp;

	// A set ready flag drops the event, so the old result survives until the ready flag is cleared
	assign take_conv = conv_done_i && !rdy_o;
	assign take_cal  = cal_done_i && !rdy_o;
	assign forced    = force_ones_i ? {W{1'b1}} : raw_i;
	assign clamp     = (forced == {W{1'b0}}) || (forced == {W{1'b1}});

	// Hardware set wins over a software or mode-write clear in the same cycle
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			rdy_o <= 1'b0;
		else if (take_conv || take_cal)
			rdy_o <= 1'b1;
		else if (mode_wr_i)
			rdy_o <= 1'b0;
		else if (sw_rdy_wr_i)
			rdy_o <= sw_rdy_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			err_o <= 1'b0;
		else if ((take_conv && clamp) || (take_cal && cal_fail_i))
			err_o <= 1'b1;
		else if (mode_wr_i)
			err_o <= 1'b0;
		else if (sw_err_wr_i)
			err_o <= sw_err_i;
	end

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
		begin
			result_wr_o <= 1'b0;
			result_o    <= {W{1'b0}};
			cal_wr_o    <= 1'b0;
		end
		else
		begin
			result_wr_o <= take_conv;
			cal_wr_o    <= take_cal && !cal_fail_i;
			if (take_conv)
				result_o <= forced;
		end
	end
endmodule

// File: dasf_status.sv
// Status register and flag logic shared by the primary and auxiliary converters
`timescale 1ns/10ps
module dasf_status
	import dasf_pkg::*;
(
	input  wire logic                   ref_clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic [7:0]             sfr_addr_i,
	input  wire logic                   sfr_wr_i,
	input  wire logic                   sfr_rd_i,
	input  wire logic [7:0]             sfr_wdata_i,
	input  wire logic [7:0]             bit_addr_i,
	input  wire logic                   bit_wr_i,
	input  wire logic                   bit_wdata_i,
	output logic      [7:0]             sfr_rdata_o,
	input  wire logic                   mode_wr_i,
	input  wire logic [2:0]             mode_i,
	input  wire logic                   prim_en_i,
	input  wire logic                   aux_en_i,
	input  wire logic                   prim_xref_i,
	input  wire logic                   aux_xref_i,
	input  wire logic                   ref_float_i,
	input  wire logic                   ref_low_i,
	input  wire logic                   prim_conv_done_i,
	input  wire logic                   prim_cal_done_i,
	input  wire logic                   prim_cal_fail_i,
	input  wire logic [DASF_PRIM_W-1:0] prim_raw_i,
	input  wire logic                   aux_conv_done_i,
	input  wire logic                   aux_cal_done_i,
	input  wire logic                   aux_cal_fail_i,
	input  wire logic [DASF_AUX_W-1:0]  aux_raw_i,
	output logic                        prim_result_wr_o,
	output logic      [DASF_PRIM_W-1:0] prim_result_o,
	output logic                        prim_cal_wr_o,
	output logic                        aux_result_wr_o,
	output logic      [DASF_AUX_W-1:0]  aux_result_o,
	output logic                        aux_cal_wr_o,
	output logic                        mode_clear_o
);
	logic                   primary_done_flag;
	logic                   aux_done_flag;
	logic                   cal_flag;
	logic                   missing_reference_flag;
	logic                   primary_clamp_error;
	logic                   aux_clamp_error;
	logic [DASF_SYNC_N-1:0] ref_async;
	logic [DASF_SYNC_N-1:0] ref_sync;
	logic                   byte_hit;
	logic                   bit_hit;
	logic [7:0]             converter_status_reg;
	logic                   conv_active;
	logic                   prim_force;
	logic                   aux_force;
	logic                   wr_prdy;
	logic                   wr_ardy;
	logic                   wr_perr;
	logic                   wr_aerr;
	logic                   val_prdy;
	logic                   val_ardy;
	logic                   val_perr;
	logic                   val_aerr;

	////////////////////////////////////////////////////////////////////////////////
	// Register decode

	assign byte_hit = sfr_wr_i && (sfr_addr_i == DASF_STATUS_ADDR);
	assign bit_hit  = bit_wr_i && !byte_hit
		&& (bit_addr_i[7:3] == DASF_STATUS_ADDR[7:3]);

	// Byte write wins when both strobes arrive together
	assign wr_prdy  = byte_hit || (bit_hit && bit_addr_i[2:0] == DASF_BIT_PRDY);
	assign wr_ardy  = byte_hit || (bit_hit && bit_addr_i[2:0] == DASF_BIT_ARDY);
	assign wr_perr  = byte_hit || (bit_hit && bit_addr_i[2:0] == DASF_BIT_PERR);
	assign wr_aerr  = byte_hit || (bit_hit && bit_addr_i[2:0] == DASF_BIT_AERR);
	assign val_prdy = byte_hit ? sfr_wdata_i[DASF_BIT_PRDY] : bit_wdata_i;
	assign val_ardy = byte_hit ? sfr_wdata_i[DASF_BIT_ARDY] : bit_wdata_i;
	assign val_perr = byte_hit ? sfr_wdata_i[DASF_BIT_PERR] : bit_wdata_i;
	assign val_aerr = byte_hit ? sfr_wdata_i[DASF_BIT_AERR] : bit_wdata_i;

	// Reserved bits are wired to zero, so writes to them have nowhere to land
	assign converter_status_reg = {primary_done_flag, aux_done_flag, cal_flag,
		missing_reference_flag, primary_clamp_error, aux_clamp_error, 2'b00};

	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			sfr_rdata_o <= DASF_STATUS_RESET;
		else if (sfr_rd_i && sfr_addr_i == DASF_STATUS_ADDR)
			sfr_rdata_o <= converter_status_reg;
		else
			sfr_rdata_o <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Reference detection

	assign ref_async = {ref_float_i, ref_low_i};

	generate
		for (genvar gi = 0; gi < DASF_SYNC_N; gi++)
		begin : g_ref_sync
			dasf_sync u_sync
			(
				.ref_clk_i (ref_clk_i),
				.rst_n_i   (rst_n_i),
				.async_i   (ref_async[gi]),
				.sync_o    (ref_sync[gi])
			);
		end
	endgenerate

	assign conv_active = (prim_en_i || aux_en_i) && (mode_i != DASF_MODE_OFF);

	// Hardware-only flag: no software path can set or clear it
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			missing_reference_flag <= 1'b0;
		else
			missing_reference_flag <= conv_active && (|ref_sync);
	end

	assign prim_force = missing_reference_flag && (prim_xref_i == DASF_REF_EXT_ON);
	assign aux_force  = missing_reference_flag && (aux_xref_i == DASF_REF_EXT_ON);

	////////////////////////////////////////////////////////////////////////////////
	// Per-converter flags

	dasf_chan #(.W(DASF_PRIM_W)) u_prim
	(
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.conv_done_i (prim_conv_done_i),
		.cal_done_i  (prim_cal_done_i),
		.cal_fail_i  (prim_cal_fail_i),
		.raw_i       (prim_raw_i),
		.force_ones_i(prim_force),
		.mode_wr_i   (mode_wr_i),
		.sw_rdy_wr_i (wr_prdy),
		.sw_rdy_i    (val_prdy),
		.sw_err_wr_i (wr_perr),
		.sw_err_i    (val_perr),
		.rdy_o       (primary_done_flag),
		.err_o       (primary_clamp_error),
		.result_wr_o (prim_result_wr_o),
		.result_o    (prim_result_o),
		.cal_wr_o    (prim_cal_wr_o)
	);

	dasf_chan #(.W(DASF_AUX_W)) u_aux
	(
		.ref_clk_i   (ref_clk_i),
		.rst_n_i     (rst_n_i),
		.conv_done_i (aux_conv_done_i),
		.cal_done_i  (aux_cal_done_i),
		.cal_fail_i  (aux_cal_fail_i),
		.raw_i       (aux_raw_i),
		.force_ones_i(aux_force),
		.mode_wr_i   (mode_wr_i),
		.sw_rdy_wr_i (wr_ardy),
		.sw_rdy_i    (val_ardy),
		.sw_err_wr_i (wr_aerr),
		.sw_err_i    (val_aerr),
		.rdy_o       (aux_done_flag),
		.err_o       (aux_clamp_error),
		.result_wr_o (aux_result_wr_o),
		.result_o    (aux_result_o),
		.cal_wr_o    (aux_cal_wr_o)
	);

	////////////////////////////////////////////////////////////////////////////////
	// Calibration flag and single-conversion return

	// Set on any calibration end, even a blocked or failed one
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			cal_flag <= 1'b0;
		else if (prim_cal_done_i || aux_cal_done_i)
			cal_flag <= 1'b1;
		else if (mode_wr_i)
			cal_flag <= 1'b0;
	end

	// The mode register owner must turn this pulse into a write of power-down
	always_ff @(posedge ref_clk_i)
	begin
		if (!rst_n_i)
			mode_clear_o <= 1'b0;
		else
			mode_clear_o <= (mode_i == DASF_MODE_SINGLE)
				&& (prim_result_wr_o || aux_result_wr_o);
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!rst_n_i);

	property p_read_status;
		sfr_rd_i && sfr_addr_i == DASF_STATUS_ADDR |=> sfr_rdata_o == $past(converter_status_reg);
	endproperty
	a_read_status: assert property (p_read_status)
		else $error("status read returned wrong value");

	property p_reserved_zero;
		sfr_rdata_o[1:0] == 2'b00;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero)
		else $error("reserved bits not zero");

	property p_prdy_set;
		prim_conv_done_i && !primary_done_flag |=> primary_done_flag;
	endproperty
	a_prdy_set: assert property (p_prdy_set)
		else $error("primary ready not set");

	property p_mode_clear;
		mode_wr_i && !prim_conv_done_i && !prim_cal_done_i && !aux_conv_done_i
			&& !aux_cal_done_i |=> !primary_done_flag && !aux_done_flag
			&& !primary_clamp_error && !aux_clamp_error && !cal_flag;
	endproperty
	a_mode_clear: assert property (p_mode_clear)
		else $error("mode write did not clear flags");

	property p_prim_block;
		primary_done_flag && (prim_conv_done_i || prim_cal_done_i)
			|=> !prim_result_wr_o && !prim_cal_wr_o && $stable(prim_result_o);
	endproperty
	a_prim_block: assert property (p_prim_block)
		else $error("primary wrote while ready set");

	property p_aux_block;
		aux_done_flag && (aux_conv_done_i || aux_cal_done_i)
			|=> !aux_result_wr_o && !aux_cal_wr_o && $stable(aux_result_o);
	endproperty
	a_aux_block: assert property (p_aux_block)
		else $error("auxiliary wrote while ready set");

	property p_cal_hold;
		cal_flag && !mode_wr_i |=> cal_flag;
	endproperty
	a_cal_hold: assert property (p_cal_hold)
		else $error("calibration flag lost without mode write");

	property p_cal_set;
		prim_cal_done_i || aux_cal_done_i |=> cal_flag;
	endproperty
	a_cal_set: assert property (p_cal_set)
		else $error("calibration flag not set");

	property p_noref_idle;
		!prim_en_i && !aux_en_i |=> !missing_reference_flag;
	endproperty
	a_noref_idle: assert property (p_noref_idle)
		else $error("missing reference flag while powered down");

	property p_noref_set;
		(conv_active && ref_float_i)[*4] |-> missing_reference_flag;
	endproperty
	a_noref_set: assert property (p_noref_set)
		else $error("missing reference not flagged");

	property p_force_ones;
		prim_conv_done_i && !primary_done_flag && prim_force
			|=> prim_result_o == {DASF_PRIM_W{1'b1}} && primary_clamp_error;
	endproperty
	a_force_ones: assert property (p_force_ones)
		else $error("result not forced to all ones");

	property p_prim_clamp;
		prim_conv_done_i && !primary_done_flag && prim_raw_i == '0 |=> primary_clamp_error;
	endproperty
	a_prim_clamp: assert property (p_prim_clamp)
		else $error("primary clamp not flagged");

	property p_prim_calfail;
		prim_cal_done_i && prim_cal_fail_i && !primary_done_flag
			|=> primary_clamp_error && !prim_cal_wr_o;
	endproperty
	a_prim_calfail: assert property (p_prim_calfail)
		else $error("failed calibration not reported");

	property p_aux_clamp;
		aux_conv_done_i && !aux_done_flag && aux_raw_i == '1 |=> aux_clamp_error;
	endproperty
	a_aux_clamp: assert property (p_aux_clamp)
		else $error("auxiliary clamp not flagged");

	property p_single_return;
		mode_i == DASF_MODE_SINGLE && prim_result_wr_o |=> mode_clear_o;
	endproperty
	a_single_return: assert property (p_single_return)
		else $error("single conversion did not request power-down");

	c_prim_conv: cover property (prim_conv_done_i ##1 primary_done_flag ##[1:20] mode_wr_i);
	c_blocked: cover property (primary_done_flag && prim_conv_done_i);
	c_noref: cover property (missing_reference_flag && prim_result_wr_o);
	c_cal_fail: cover property (aux_cal_done_i && aux_cal_fail_i ##1 aux_clamp_error);
endmodule

// File: dasf_status_tb.sv
// Self-checking testbench for the converter status flag logic
`timescale 1ns/10ps
module dasf_status_tb;
	import dasf_pkg::*;
	typedef struct {logic [23:0] pr; logic [15:0] ar; logic [7:0] st;} dasf_row_t;
	logic                   ref_clk_i, rst_n_i, sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i;
	logic [7:0]             sfr_addr_i, sfr_wdata_i, bit_addr_i, sfr_rdata_o;
	logic                   mode_wr_i, prim_en_i, aux_en_i, prim_xref_i, aux_xref_i;
	logic [2:0]             mode_i;
	logic                   ref_float_i, ref_low_i, prim_conv_done_i, prim_cal_done_i;
	logic                   prim_cal_fail_i, aux_conv_done_i, aux_cal_done_i, aux_cal_fail_i;
	logic [DASF_PRIM_W-1:0] prim_raw_i, prim_result_o;
	logic [DASF_AUX_W-1:0]  aux_raw_i, aux_result_o;
	logic                   prim_result_wr_o, prim_cal_wr_o, aux_result_wr_o, aux_cal_wr_o;
	logic                   mode_clear_o;
	int                     error_cnt, num_checks;
	dasf_row_t              rows [4];
	////////////////////////////////////////////////////////////////////////////////
	dasf_status dasf_status_inst (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
		.sfr_addr_i(sfr_addr_i), .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i),
		.sfr_wdata_i(sfr_wdata_i), .bit_addr_i(bit_addr_i), .bit_wr_i(bit_wr_i),
		.bit_wdata_i(bit_wdata_i), .sfr_rdata_o(sfr_rdata_o), .mode_wr_i(mode_wr_i),
		.mode_i(mode_i), .prim_en_i(prim_en_i), .aux_en_i(aux_en_i),
		.prim_xref_i(prim_xref_i), .aux_xref_i(aux_xref_i), .ref_float_i(ref_float_i),
		.ref_low_i(ref_low_i), .prim_conv_done_i(prim_conv_done_i),
		.prim_cal_done_i(prim_cal_done_i), .prim_cal_fail_i(prim_cal_fail_i),
		.prim_raw_i(prim_raw_i), .aux_conv_done_i(aux_conv_done_i),
		.aux_cal_done_i(aux_cal_done_i), .aux_cal_fail_i(aux_cal_fail_i),
		.aux_raw_i(aux_raw_i), .prim_result_wr_o(prim_result_wr_o),
		.prim_result_o(prim_result_o), .prim_cal_wr_o(prim_cal_wr_o),
		.aux_result_wr_o(aux_result_wr_o), .aux_result_o(aux_result_o),
		.aux_cal_wr_o(aux_cal_wr_o), .mode_clear_o(mode_clear_o));
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		ref_clk_i = 1'b0;
		forever #20 ref_clk_i = ~ref_clk_i;
	end
	task automatic tick();
		@(posedge ref_clk_i);
		#1;
	endtask
	task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk_rd(input logic [7:0] addr, input logic [7:0] exp);
		sfr_addr_i = addr;
		sfr_rd_i = 1'b1;
		tick();
		sfr_rd_i = 1'b0;
		check("status", {16'h0000, sfr_rdata_o}, {16'h0000, exp});
	endtask
	task automatic mode_write();
		mode_wr_i = 1'b1;
		tick();
		mode_wr_i = 1'b0;
	endtask
	task automatic byte_write(input logic [7:0] d);
		sfr_addr_i = DASF_STATUS_ADDR;
		sfr_wdata_i = d;
		sfr_wr_i = 1'b1;
		tick();
		sfr_wr_i = 1'b0;
	endtask
	task automatic bit_write(input logic [7:0] a, input logic v);
		bit_addr_i = a;
		bit_wdata_i = v;
		bit_wr_i = 1'b1;
		tick();
		bit_wr_i = 1'b0;
	endtask
	// The converters selected by pe and ae finish in the same cycle; write strobes are looked at the cycle after
	task automatic conv(input logic [23:0] pr, input logic [15:0] ar, input logic pe,
		input logic ae);
		prim_raw_i = pr;
		aux_raw_i = ar;
		prim_conv_done_i = pe;
		aux_conv_done_i = ae;
		tick();
		prim_conv_done_i = 1'b0;
		aux_conv_done_i = 1'b0;
	endtask
	task automatic cal(input logic p, input logic pf, input logic a, input logic af);
		prim_cal_done_i = p;
		prim_cal_fail_i = pf;
		aux_cal_done_i = a;
		aux_cal_fail_i = af;
		tick();
		{prim_cal_done_i, prim_cal_fail_i, aux_cal_done_i, aux_cal_fail_i} = 4'h0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (5000) @(posedge ref_clk_i);
		error_cnt++;
		tally_and_finish();
	end
	initial
	begin
		error_cnt = 0;
		num_checks = 0;
		{sfr_wr_i, sfr_rd_i, bit_wr_i, bit_wdata_i, mode_wr_i} = 5'h00;
		{sfr_addr_i, sfr_wdata_i, bit_addr_i} = 24'h000000;
		{prim_en_i, aux_en_i, prim_xref_i, aux_xref_i, ref_float_i, ref_low_i} = 6'h30;
		{prim_conv_done_i, prim_cal_done_i, prim_cal_fail_i} = 3'h0;
		{aux_conv_done_i, aux_cal_done_i, aux_cal_fail_i} = 3'h0;
		mode_i = 3'h3;
		prim_raw_i = 24'h000000;
		aux_raw_i = 16'h0000;
		rst_n_i = 1'b0;
		rows[0] = '{24'h123456, 16'h4321, 8'hc0};
		rows[1] = '{24'hffffff, 16'h0001, 8'hc8};
		rows[2] = '{24'h000001, 16'h0000, 8'hc4};
		rows[3] = '{24'h000000, 16'hffff, 8'hcc};
		repeat (2) tick();
		rst_n_i = 1'b1;
		tick();
		chk_rd(DASF_STATUS_ADDR, DASF_STATUS_RESET);
		chk_rd(8'hd9, 8'h00);
		$display("reset test done");
		foreach (rows[i])
		begin
			mode_write();
			conv(rows[i].pr, rows[i].ar, 1'b1, 1'b1);
			check("prim_wr", prim_result_wr_o, 24'h1);
			check("prim_res", prim_result_o, rows[i].pr);
			check("aux_wr", aux_result_wr_o, 24'h1);
			check("aux_res", aux_result_o, rows[i].ar);
			chk_rd(DASF_STATUS_ADDR, rows[i].st);
		end
		$display("table test done");
		// Results arriving while both ready flags stand must be dropped
		conv(24'h0000aa, 16'h00bb, 1'b1, 1'b1);
		check("prim_wr", prim_result_wr_o, 24'h0);
		check("aux_wr", aux_result_wr_o, 24'h0);
		check("prim_res", prim_result_o, 24'h000000);
		chk_rd(DASF_STATUS_ADDR, 8'hcc);
		bit_write(8'hdf, 1'b0);
		chk_rd(DASF_STATUS_ADDR, 8'h4c);
		conv(24'h0000aa, 16'h00bb, 1'b1, 1'b1);
		check("prim_res", prim_result_o, 24'h0000aa);
		check("aux_wr", aux_result_wr_o, 24'h0);
		mode_write();
		chk_rd(DASF_STATUS_ADDR, 8'h00);
		byte_write(8'hff);
		chk_rd(DASF_STATUS_ADDR, 8'hcc);
		$display("gating test done");
		mode_write();
		cal(1'b1, 1'b1, 1'b0, 1'b0);
		check("prim_cal_wr", prim_cal_wr_o, 24'h0);
		chk_rd(DASF_STATUS_ADDR, 8'ha8);
		byte_write(8'h00);
		chk_rd(DASF_STATUS_ADDR, 8'h20);
		bit_write(8'hdd, 1'b0);
		chk_rd(DASF_STATUS_ADDR, 8'h20);
		cal(1'b0, 1'b0, 1'b1, 1'b0);
		check("aux_cal_wr", aux_cal_wr_o, 24'h1);
		bit_write(8'hde, 1'b0);
		cal(1'b1, 1'b0, 1'b1, 1'b1);
		check("prim_cal_wr", prim_cal_wr_o, 24'h1);
		check("aux_cal_wr", aux_cal_wr_o, 24'h0);
		chk_rd(DASF_STATUS_ADDR, 8'he4);
		mode_write();
		chk_rd(DASF_STATUS_ADDR, 8'h00);
		$display("calibration test done");
		// Detector levels pass a synchroniser, so allow a few cycles to settle
		ref_low_i = 1'b1;
		prim_xref_i = 1'b1;
		repeat (5) tick();
		chk_rd(DASF_STATUS_ADDR, 8'h10);
		conv(24'h123456, 16'h1234, 1'b1, 1'b1);
		check("prim_res", prim_result_o, 24'hffffff);
		check("aux_res", aux_result_o, 24'h1234);
		chk_rd(DASF_STATUS_ADDR, 8'hd8);
		{prim_en_i, aux_en_i} = 2'b00;
		repeat (5) tick();
		chk_rd(DASF_STATUS_ADDR, 8'hc8);
		{prim_en_i, aux_en_i, ref_low_i, ref_float_i} = 4'b1101;
		repeat (5) tick();
		chk_rd(DASF_STATUS_ADDR, 8'hd8);
		mode_i = DASF_MODE_OFF;
		repeat (5) tick();
		chk_rd(DASF_STATUS_ADDR, 8'hc8);
		// Only the auxiliary side uses the external reference now
		mode_i = 3'h3;
		{prim_xref_i, aux_xref_i} = 2'b01;
		repeat (5) tick();
		mode_write();
		conv(24'h123456, 16'h1234, 1'b1, 1'b1);
		check("prim_res", prim_result_o, 24'h123456);
		check("aux_res", aux_result_o, 24'h00ffff);
		chk_rd(DASF_STATUS_ADDR, 8'hd4);
		{ref_float_i, prim_xref_i, aux_xref_i} = 3'b000;
		$display("reference test done");
		mode_i = DASF_MODE_SINGLE;
		mode_write();
		conv(24'h0a0b0c, 16'h0000, 1'b1, 1'b0);
		check("mode_clear", mode_clear_o, 24'h0);
		tick();
		check("mode_clear", mode_clear_o, 24'h1);
		tick();
		mode_i = 3'h3;
		mode_write();
		chk_rd(DASF_STATUS_ADDR, 8'h00);
		$display("single conversion test done");
		// A reset in mid-run must drop every flag and the held result
		byte_write(8'hff);
		rst_n_i = 1'b0;
		repeat (2) tick();
		rst_n_i = 1'b1;
		chk_rd(DASF_STATUS_ADDR, DASF_STATUS_RESET);
		check("prim_res", prim_result_o, 24'h000000);
		$display("mid-run reset test done");
		tally_and_finish();
	end
endmodule
